// >>> bench/pop_pins.sv
// Pin-side model of the two shared ports and whatever drives them from outside.
`timescale 1ns/1ps
module pop_pins
(
	input  wire logic [7:0] lo_out,
	input  wire logic [7:0] lo_oe,
	input  wire logic [7:0] hi_out,
	input  wire logic [7:0] hi_oe,
	input  wire logic [7:0] ext,
	output logic      [7:0] lo_pin,
	output logic      [7:0] hi_pin
);
	// pin resolution
	// Undriven pins take an outside level; the high port sees its inverse so halves differ.
	always_comb
	begin
		lo_pin = (lo_oe & lo_out) | (~lo_oe & ext);
		hi_pin = (hi_oe & hi_out) | (~hi_oe & ~ext);
	end
endmodule : pop_pins

// >>> bench/pop_regs_sva.sv
// Assertions on the bus and pin ports of the pattern output registers.
`timescale 1ns/1ps
module pop_regs_chk
	import pop_pkg::*;
#(
	parameter int PORT_W = 8
)
(
	input wire logic                  CLK_SYS,
	input wire logic                  SYS_RST,
	input wire logic                  PSEL,
	input wire logic                  PENABLE,
	input wire logic                  PWRITE,
	input wire logic [POP_ADDR_W-1:0] PADDR,
	input wire logic [31:0]           PWDATA,
	input wire logic [31:0]           PRDATA,
	input wire logic                  PREADY,
	input wire logic                  PSLVERR,
	input wire logic [POP_TIMERS-1:0] TIMER_MATCH,
	input wire logic [PORT_W-1:0]     PORT_LO_IN,
	input wire logic [PORT_W-1:0]     PORT_LO_OUT,
	input wire logic [PORT_W-1:0]     PORT_LO_OE,
	input wire logic [PORT_W-1:0]     PORT_HI_IN,
	input wire logic [PORT_W-1:0]     PORT_HI_OUT,
	input wire logic [PORT_W-1:0]     PORT_HI_OE
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SYS_RST);
	logic [19:0]       idx;
	logic              acc;
	logic              wr;
	logic              mapped;
	logic [PORT_W-1:0] nde_r;
	logic [PORT_W-1:0] hi_nde_r;
	// Decode of the completing transfer.
	assign idx = PADDR[POP_ADDR_W-1:POP_IDX_LSB];
	assign acc = PSEL && PENABLE && PREADY;
	assign wr  = acc && PWRITE;
	assign mapped = idx inside {POP_IDX_LO_DIR, POP_IDX_HI_DIR, POP_IDX_MODE, POP_IDX_CTRL,
		POP_IDX_HI_NDE, POP_IDX_LO_NDE, POP_IDX_HI_ND, POP_IDX_LO_ND, POP_IDX_HI_ND_G2,
		POP_IDX_LO_ND_G0, POP_IDX_LO_DATA, POP_IDX_HI_DATA};
	// Shadows of the low and high enable registers, because masked writes depend on them.
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			nde_r    <= '0;
			hi_nde_r <= '0;
		end
		else if (wr && idx == POP_IDX_LO_NDE)
			nde_r <= PWDATA[PORT_W-1:0];
		else if (wr && idx == POP_IDX_HI_NDE)
			hi_nde_r <= PWDATA[PORT_W-1:0];
	end
	property p_decode;
		acc |-> PSLVERR == !mapped;
	endproperty
	property p_err_access;
		PSLVERR |-> PSEL && PENABLE;
	endproperty
	property p_lo_oe;
		wr && idx == POP_IDX_LO_DIR |=> PORT_LO_OE == $past(PWDATA[PORT_W-1:0]);
	endproperty
	property p_hi_oe;
		wr && idx == POP_IDX_HI_DIR |=> PORT_HI_OE == $past(PWDATA[PORT_W-1:0]);
	endproperty
	property p_dir_read;
		acc && !PWRITE && (idx == POP_IDX_LO_DIR || idx == POP_IDX_HI_DIR) |-> PRDATA == 32'h0;
	endproperty
	property p_lo_hold;
		!(wr && idx == POP_IDX_LO_DATA) && TIMER_MATCH == '0 |=> $stable(PORT_LO_OUT);
	endproperty
	property p_hi_hold;
		!(wr && idx == POP_IDX_HI_DATA) && TIMER_MATCH == '0 |=> $stable(PORT_HI_OUT);
	endproperty
	property p_lo_mask;
		wr && idx == POP_IDX_LO_DATA && TIMER_MATCH == '0 |=> PORT_LO_OUT ==
			(($past(PORT_LO_OUT) & $past(nde_r)) | ($past(PWDATA[PORT_W-1:0]) & ~$past(nde_r)));
	endproperty
	property p_hi_mask;
		wr && idx == POP_IDX_HI_DATA && TIMER_MATCH == '0 |=> PORT_HI_OUT ==
			(($past(PORT_HI_OUT) & $past(hi_nde_r)) |
			($past(PWDATA[PORT_W-1:0]) & ~$past(hi_nde_r)));
	endproperty
	a_decode: assert property (p_decode) else $error("bad error response");
	a_err_access: assert property (p_err_access) else $error("stray error");
	a_lo_oe: assert property (p_lo_oe) else $error("low enable wrong");
	a_hi_oe: assert property (p_hi_oe) else $error("high enable wrong");
	a_dir_read: assert property (p_dir_read) else $error("direction readable");
	a_lo_hold: assert property (p_lo_hold) else $error("low pins moved");
	a_hi_hold: assert property (p_hi_hold) else $error("high pins moved");
	a_lo_mask: assert property (p_lo_mask) else $error("masked write wrong");
	a_hi_mask: assert property (p_hi_mask) else $error("high masked write wrong");
	c_data_wr: cover property (wr && idx == POP_IDX_LO_DATA);
	c_trigger: cover property (TIMER_MATCH != '0);
	c_error: cover property (PSLVERR);
	c_split: cover property (acc && (idx == POP_IDX_LO_ND_G0 || idx == POP_IDX_HI_ND_G2));
endmodule : pop_regs_chk

bind pop_regs pop_regs_chk #(.PORT_W(PORT_W)) u_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TIMER_MATCH(TIMER_MATCH),
	.PORT_LO_IN(PORT_LO_IN), .PORT_LO_OUT(PORT_LO_OUT), .PORT_LO_OE(PORT_LO_OE),
	.PORT_HI_IN(PORT_HI_IN), .PORT_HI_OUT(PORT_HI_OUT), .PORT_HI_OE(PORT_HI_OE));

// >>> bench/pop_regs_test.sv
// Self-checking bench for the pattern output port registers.
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module pop_regs_test
	import pop_pkg::*;
;
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [21:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic [2:0]  tm;
	logic [7:0]  ext;
	logic [7:0]  lo_in;
	logic [7:0]  lo_out;
	logic [7:0]  lo_oe;
	logic [7:0]  hi_in;
	logic [7:0]  hi_out;
	logic [7:0]  hi_oe;
	logic [7:0]  v;
	logic [7:0]  w;
	logic [7:0]  me;
	logic [7:0]  q[$];
	int          miscompares;
	int          cmp_count;
	int          seed;
	logic [19:0] ri [10] = '{POP_IDX_MODE, POP_IDX_CTRL, POP_IDX_HI_NDE, POP_IDX_LO_NDE,
		POP_IDX_HI_ND, POP_IDX_LO_ND, POP_IDX_LO_DIR, POP_IDX_HI_DIR, POP_IDX_HI_ND_G2,
		POP_IDX_LO_ND_G0};
	logic [7:0]  rv [10] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};

	pop_regs DUT (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TIMER_MATCH(tm), .PORT_LO_IN(lo_in), .PORT_LO_OUT(lo_out),
		.PORT_LO_OE(lo_oe), .PORT_HI_IN(hi_in), .PORT_HI_OUT(hi_out), .PORT_HI_OE(hi_oe));
	pop_pins u_pins (.lo_out(lo_out), .lo_oe(lo_oe), .hi_out(hi_out), .hi_oe(hi_oe),
		.ext(ext), .lo_pin(lo_in), .hi_pin(hi_in));

	// Free-running system clock.
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic final_report();
		// Notes never consumed mean a read the monitor missed.
		if (q.size() != 0)
		begin
			miscompares++;
			$display("[ERR] t=%0t notes left %h exp %h", $time, q.size(), 0);
		end
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// One bus transfer; a read leaves its expected byte in the queue for the monitor.
	task automatic apb(input logic wr_i, input logic [19:0] idx, input logic [7:0] d,
		input logic [7:0] e);
		int n;
		if (!wr_i)
			q.push_back(e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr_i;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			miscompares++;
			final_report();
		end
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	// A one-cycle compare-match pulse; the load is visible just after its edge.
	task automatic pulse(input logic [2:0] t);
		@(posedge clk);
		tm <= t;
		@(posedge clk);
		tm <= 3'b000;
		#1;
	endtask : pulse

	// Read data is taken in the cycle that completes the read, oldest note first.
	always @(posedge clk)
	begin
		if (psel && penable && pready && !pwrite)
		begin
			if (q.size() == 0)
			begin
				miscompares++;
				$display("[ERR] t=%0t read %h with no note, exp %h", $time, prdata, 32'h0);
			end
			else
			begin
				me = q.pop_front();
				`CHK(prdata, {24'h0, me})
			end
		end
	end

	initial
	begin
		seed = 33481;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		tm = 3'b000;
		ext = 8'($random(seed));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (ri[i])
			apb(1'b0, ri[i], 8'h00, rv[i]);
		apb(1'b0, POP_IDX_LO_DATA, 8'h00, ext);
		apb(1'b0, POP_IDX_HI_DATA, 8'h00, ~ext);
		$display("test reset values done");
		v = 8'($random(seed));
		w = 8'($random(seed));
		apb(1'b1, POP_IDX_MODE, v, 8'h00);
		apb(1'b0, POP_IDX_MODE, 8'h00, v);
		apb(1'b1, POP_IDX_LO_DIR, 8'hff, 8'h00);
		apb(1'b1, POP_IDX_HI_DIR, 8'hff, 8'h00);
		apb(1'b0, POP_IDX_LO_DIR, 8'h00, 8'h00);
		`CHK({lo_oe, hi_oe}, 16'hffff)
		apb(1'b1, POP_IDX_LO_DATA, v, 8'h00);
		apb(1'b1, POP_IDX_HI_DATA, w, 8'h00);
		`CHK({lo_out, hi_out}, {v, w})
		$display("test direction and data done");
		apb(1'b1, POP_IDX_LO_NDE, 8'h0f, 8'h00);
		apb(1'b1, POP_IDX_HI_NDE, 8'hf0, 8'h00);
		apb(1'b1, POP_IDX_LO_DATA, ~v, 8'h00);
		apb(1'b1, POP_IDX_HI_DATA, ~w, 8'h00);
		v = {~v[7:4], v[3:0]};
		w = {w[7:4], ~w[3:0]};
		apb(1'b0, POP_IDX_LO_DATA, 8'h00, v);
		apb(1'b0, POP_IDX_HI_DATA, 8'h00, w);
		// Control still at reset: every group selects no trigger, so nothing loads.
		pulse(3'b111);
		`CHK({lo_out, hi_out}, {v, w})
		$display("test masked writes done");
		apb(1'b1, POP_IDX_CTRL, 8'h50, 8'h00);
		apb(1'b0, POP_IDX_CTRL, 8'h00, 8'h50);
		apb(1'b1, POP_IDX_LO_ND, 8'ha5, 8'h00);
		apb(1'b1, POP_IDX_HI_ND, 8'h3c, 8'h00);
		apb(1'b1, POP_IDX_LO_ND_G0, 8'h00, 8'h00);
		apb(1'b0, POP_IDX_LO_ND, 8'h00, 8'ha5);
		apb(1'b0, POP_IDX_LO_ND_G0, 8'h00, 8'hff);
		apb(1'b0, POP_IDX_HI_ND, 8'h00, 8'h3c);
		pulse(3'b001);
		`CHK(lo_out, {v[7:4], 4'h5})
		pulse(3'b010);
		`CHK(hi_out, {4'h3, w[3:0]})
		$display("test shared trigger done");
		apb(1'b1, POP_IDX_CTRL, 8'h48, 8'h00);
		apb(1'b1, POP_IDX_LO_ND, 8'h9c, 8'h00);
		apb(1'b1, POP_IDX_LO_ND_G0, 8'h03, 8'h00);
		apb(1'b1, POP_IDX_HI_ND, 8'h7e, 8'h00);
		apb(1'b1, POP_IDX_HI_ND_G2, 8'h12, 8'h00);
		apb(1'b0, POP_IDX_LO_ND, 8'h00, 8'h9f);
		apb(1'b0, POP_IDX_LO_ND_G0, 8'h00, 8'hf3);
		apb(1'b0, POP_IDX_HI_ND, 8'h00, 8'h7f);
		apb(1'b0, POP_IDX_HI_ND_G2, 8'h00, 8'hf2);
		apb(1'b1, POP_IDX_LO_NDE, 8'hff, 8'h00);
		pulse(3'b100);
		`CHK(lo_out, 8'h95)
		pulse(3'b001);
		`CHK(lo_out, 8'h93)
		$display("test split trigger done");
		apb(1'b1, 20'h00000, 8'hff, 8'h00);
		`CHK(err, 1'b1)
		apb(1'b0, 20'h00000, 8'h00, 8'h00);
		apb(1'b0, POP_IDX_LO_DATA, 8'h00, 8'h93);
		$display("test unmapped access done");
		final_report();
	end
endmodule : pop_regs_test

// >>> hw/pop_pkg.sv
// Constants, register map and trigger encodings of the pattern output port registers.
// Functional notes
// - Sixteen pattern outputs form four groups of four: 0-3, 4-7, 8-11 and 12-15.
// - Register addresses are decoded from a 20-bit register index in the advanced address map.
// - The output mode register resets to f0 and the trigger control register to ff.
// - Both enable, both next-data, both direction and both port data registers reset to 00.
// - Low next data sits whole at fffa5 with one trigger, else group 1 at fffa5 and group 0 at fffa7.
// - High next data sits whole at fffa4 with one trigger, else group 3 at fffa4 and group 2 at fffa6.
// - Each port direction register is 8-bit write-only, one bit per pin selecting input or output.
// - Low port pins 7-0 carry pattern outputs 7-0 and high port pins 7-0 carry outputs 15-8.
// - Low port data holds groups 0 and 1; bits enabled for pattern output ignore writes.
// - High port data holds groups 2 and 3; bits enabled for pattern output ignore writes.
// - A selected compare-match event copies next data into the enabled port data bits.
// - Unused halves and addresses of the next-data registers ignore writes and read as ones.
package pop_pkg;

	// Register indices; the APB byte address is four times the index.
	localparam logic [19:0] POP_IDX_LO_DIR   = 20'hee009;
	localparam logic [19:0] POP_IDX_HI_DIR   = 20'hee00a;
	localparam logic [19:0] POP_IDX_MODE     = 20'hfffa0;
	localparam logic [19:0] POP_IDX_CTRL     = 20'hfffa1;
	localparam logic [19:0] POP_IDX_HI_NDE   = 20'hfffa2;
	localparam logic [19:0] POP_IDX_LO_NDE   = 20'hfffa3;
	localparam logic [19:0] POP_IDX_HI_ND    = 20'hfffa4;
	localparam logic [19:0] POP_IDX_LO_ND    = 20'hfffa5;
	localparam logic [19:0] POP_IDX_HI_ND_G2 = 20'hfffa6;
	localparam logic [19:0] POP_IDX_LO_ND_G0 = 20'hfffa7;
	localparam logic [19:0] POP_IDX_LO_DATA  = 20'hfffd9;
	localparam logic [19:0] POP_IDX_HI_DATA  = 20'hfffda;

	// Index field position inside the APB byte address.
	localparam int POP_IDX_LSB = 2;
	localparam int POP_IDX_W   = 20;
	localparam int POP_ADDR_W  = POP_IDX_LSB + POP_IDX_W;

	// Reset values, and the read value of unused next-data bits.
	localparam logic [7:0] POP_RST_MODE  = 8'hf0;
	localparam logic [7:0] POP_RST_CTRL  = 8'hff;
	localparam logic [7:0] POP_RST_ZERO  = 8'h00;
	localparam logic [7:0] POP_RESERVED  = 8'hff;

	// Trigger select field: two bits per group in the trigger control register.
	localparam int POP_SEL_W    = 2;
	localparam int POP_GROUPS   = 4;
	localparam int POP_GROUP_W  = 4;
	localparam int POP_TIMERS   = 3;
	localparam logic [1:0] POP_SEL_NONE = 2'h3;

	// Next-data byte placement as seen by software.
	typedef enum logic [1:0] {
		POP_ND_WHOLE,
		POP_ND_UPPER,
		POP_ND_LOWER,
		POP_ND_NONE
	} pop_nd_view_t;

endpackage : pop_pkg

// >>> hw/pop_port.sv
// One 8-bit port: direction register, port data register and pin drive.
`timescale 1ns/1ps
module pop_port
	import pop_pkg::*;
#(
	parameter int W = 8
)
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         dir_wr,
	input  wire logic         data_wr,
	input  wire logic [W-1:0] wdata,
	input  wire logic [W-1:0] pattern_en,
	input  wire logic [W-1:0] load_mask,
	input  wire logic [W-1:0] next_data,
	output logic      [W-1:0] dir_r,
	output logic      [W-1:0] data_r,
	output logic      [W-1:0] pin_out,
	output logic      [W-1:0] pin_oe
);

	logic [W-1:0] data_nxt;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			dir_r <= W'(POP_RST_ZERO);
		else if (dir_wr)
			dir_r <= wdata;
	end

	// Software reaches only bits not owned by the pattern unit; the trigger loads the rest.
	// Both masks are disjoint, so a write and a load in one cycle never collide.
	always_comb
	begin
		data_nxt = data_r;
		if (data_wr)
			data_nxt = (data_r & pattern_en) | (wdata & ~pattern_en);
		data_nxt = (data_nxt & ~load_mask) | (next_data & load_mask);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			data_r <= W'(POP_RST_ZERO);
		else
			data_r <= data_nxt;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pin_out <= '0;
			pin_oe  <= '0;
		end
		else
		begin
			pin_out <= data_nxt;
			pin_oe  <= (dir_wr) ? wdata : dir_r;
		end
	end

endmodule : pop_port

// >>> hw/pop_regs.sv
// APB register front end of the pattern output unit with its two shared ports.
`timescale 1ns/1ps
module pop_regs
	import pop_pkg::*;
#(
	parameter int PORT_W = 8
)
(
	input  wire logic                  CLK_SYS,
	input  wire logic                  SYS_RST,
	input  wire logic                  PSEL,
	input  wire logic                  PENABLE,
	input  wire logic                  PWRITE,
	input  wire logic [POP_ADDR_W-1:0] PADDR,
	input  wire logic [31:0]           PWDATA,
	output logic      [31:0]           PRDATA,
	output logic                       PREADY,
	output logic                       PSLVERR,
	input  wire logic [POP_TIMERS-1:0] TIMER_MATCH,
	input  wire logic [PORT_W-1:0]     PORT_LO_IN,
	output logic      [PORT_W-1:0]     PORT_LO_OUT,
	output logic      [PORT_W-1:0]     PORT_LO_OE,
	input  wire logic [PORT_W-1:0]     PORT_HI_IN,
	output logic      [PORT_W-1:0]     PORT_HI_OUT,
	output logic      [PORT_W-1:0]     PORT_HI_OE
);

	logic [7:0]            mode_r;
	logic [7:0]            ctrl_r;
	logic [7:0]            lo_nde_r;
	logic [7:0]            hi_nde_r;
	logic [7:0]            lo_nd_r;
	logic [7:0]            hi_nd_r;
	logic [31:0]           prdata_r;
	logic [POP_IDX_W-1:0]  idx;
	logic                  wr_acc;
	logic                  rd_setup;
	logic                  mapped;
	logic                  lo_same;
	logic                  hi_same;
	pop_nd_view_t          lo_view_a5;
	pop_nd_view_t          lo_view_a7;
	pop_nd_view_t          hi_view_a4;
	pop_nd_view_t          hi_view_a6;
	logic [POP_GROUPS-1:0] fire;
	logic [15:0]           load_mask;
	logic [15:0]           nde_all;
	logic [7:0]            lo_dir;
	logic [7:0]            hi_dir;
	logic [7:0]            lo_data;
	logic [7:0]            hi_data;
	logic [7:0]            lo_pin_s;
	logic [7:0]            hi_pin_s;
	logic [7:0]            rd_byte;

	// Pick the compare-match source of one group; the spare code selects none.
	function automatic logic sel_match(input logic [1:0] sel, input logic [POP_TIMERS-1:0] m);
		logic hit;
		hit = 1'b0;
		if (sel != POP_SEL_NONE)
			hit = m[sel];
		return hit;
	endfunction : sel_match

	// Which part of a next-data byte an address shows, given the trigger sharing.
	function automatic pop_nd_view_t nd_view(input logic primary, input logic same);
		pop_nd_view_t v;
		v = POP_ND_NONE;
		if (primary && same)
			v = POP_ND_WHOLE;
		else if (primary)
			v = POP_ND_UPPER;
		else if (!same)
			v = POP_ND_LOWER;
		return v;
	endfunction : nd_view

	// Bits of the next-data byte that an address with a given view may touch.
	function automatic logic [7:0] nd_mask(input pop_nd_view_t v);
		logic [7:0] m;
		m = 8'h00;
		case (v)
			POP_ND_WHOLE: m = 8'hff;
			POP_ND_UPPER: m = 8'hf0;
			POP_ND_LOWER: m = 8'h0f;
			default:      m = 8'h00;
		endcase
		return m;
	endfunction : nd_mask

	assign idx      = PADDR[POP_ADDR_W-1:POP_IDX_LSB];
	assign wr_acc   = PSEL & PENABLE & PWRITE;
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

	// Groups that pick the same select code share one trigger.
	assign lo_same = (ctrl_r[1:0] == ctrl_r[3:2]);
	assign hi_same = (ctrl_r[5:4] == ctrl_r[7:6]);

	assign lo_view_a5 = nd_view(1'b1, lo_same);
	assign lo_view_a7 = nd_view(1'b0, lo_same);
	assign hi_view_a4 = nd_view(1'b1, hi_same);
	assign hi_view_a6 = nd_view(1'b0, hi_same);

	// Every listed index answers; anything else reports a slave error.
	always_comb
	begin
		mapped = 1'b0;
		if (idx == POP_IDX_LO_DIR)
			mapped = 1'b1;
		else if (idx == POP_IDX_HI_DIR)
			mapped = 1'b1;
		else if (idx == POP_IDX_MODE)
			mapped = 1'b1;
		else if (idx == POP_IDX_CTRL)
			mapped = 1'b1;
		else if (idx == POP_IDX_HI_NDE)
			mapped = 1'b1;
		else if (idx == POP_IDX_LO_NDE)
			mapped = 1'b1;
		else if (idx == POP_IDX_HI_ND)
			mapped = 1'b1;
		else if (idx == POP_IDX_LO_ND)
			mapped = 1'b1;
		else if (idx == POP_IDX_HI_ND_G2)
			mapped = 1'b1;
		else if (idx == POP_IDX_LO_ND_G0)
			mapped = 1'b1;
		else if (idx == POP_IDX_LO_DATA)
			mapped = 1'b1;
		else if (idx == POP_IDX_HI_DATA)
			mapped = 1'b1;
	end

	// Zero wait states: data is prepared in the setup cycle, so ready can stay high.
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;
	assign PRDATA  = prdata_r;

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			mode_r <= POP_RST_MODE;
		else if (wr_acc && idx == POP_IDX_MODE)
			mode_r <= PWDATA[7:0];
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			ctrl_r <= POP_RST_CTRL;
		else if (wr_acc && idx == POP_IDX_CTRL)
			ctrl_r <= PWDATA[7:0];
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
		begin
			lo_nde_r <= POP_RST_ZERO;
			hi_nde_r <= POP_RST_ZERO;
		end
		else if (wr_acc && idx == POP_IDX_LO_NDE)
			lo_nde_r <= PWDATA[7:0];
		else if (wr_acc && idx == POP_IDX_HI_NDE)
			hi_nde_r <= PWDATA[7:0];
	end

	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			lo_nd_r <= POP_RST_ZERO;
		else if (wr_acc && idx == POP_IDX_LO_ND)
			lo_nd_r <= (lo_nd_r & ~nd_mask(lo_view_a5)) | (PWDATA[7:0] & nd_mask(lo_view_a5));
		else if (wr_acc && idx == POP_IDX_LO_ND_G0)
			lo_nd_r <= (lo_nd_r & ~nd_mask(lo_view_a7)) | (PWDATA[7:0] & nd_mask(lo_view_a7));
	end

	// Same masking for the high byte; a switch of sharing keeps the stored bits.
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			hi_nd_r <= POP_RST_ZERO;
		else if (wr_acc && idx == POP_IDX_HI_ND)
			hi_nd_r <= (hi_nd_r & ~nd_mask(hi_view_a4)) | (PWDATA[7:0] & nd_mask(hi_view_a4));
		else if (wr_acc && idx == POP_IDX_HI_ND_G2)
			hi_nd_r <= (hi_nd_r & ~nd_mask(hi_view_a6)) | (PWDATA[7:0] & nd_mask(hi_view_a6));
	end

	assign nde_all = {hi_nde_r, lo_nde_r};

	generate
		for (genvar g = 0; g < POP_GROUPS; g++)
		begin : g_group
			assign fire[g] = sel_match(ctrl_r[g*POP_SEL_W +: POP_SEL_W], TIMER_MATCH);
			assign load_mask[g*POP_GROUP_W +: POP_GROUP_W] =
				nde_all[g*POP_GROUP_W +: POP_GROUP_W] & {POP_GROUP_W{fire[g]}};
		end
	endgenerate

	// Pin levels pass two flops before any read path sees them.
	pop_sync #(.W(PORT_W)) u_lo_sync
	(
		.clk      (CLK_SYS),
		.rst      (SYS_RST),
		.async_in (PORT_LO_IN),
		.sync_out (lo_pin_s)
	);

	pop_sync #(.W(PORT_W)) u_hi_sync
	(
		.clk      (CLK_SYS),
		.rst      (SYS_RST),
		.async_in (PORT_HI_IN),
		.sync_out (hi_pin_s)
	);

	pop_port #(.W(PORT_W)) u_lo_port
	(
		.clk        (CLK_SYS),
		.rst        (SYS_RST),
		.dir_wr     (wr_acc && idx == POP_IDX_LO_DIR),
		.data_wr    (wr_acc && idx == POP_IDX_LO_DATA),
		.wdata      (PWDATA[7:0]),
		.pattern_en (lo_nde_r),
		.load_mask  (load_mask[7:0]),
		.next_data  (lo_nd_r),
		.dir_r      (lo_dir),
		.data_r     (lo_data),
		.pin_out    (PORT_LO_OUT),
		.pin_oe     (PORT_LO_OE)
	);

	pop_port #(.W(PORT_W)) u_hi_port
	(
		.clk        (CLK_SYS),
		.rst        (SYS_RST),
		.dir_wr     (wr_acc && idx == POP_IDX_HI_DIR),
		.data_wr    (wr_acc && idx == POP_IDX_HI_DATA),
		.wdata      (PWDATA[7:0]),
		.pattern_en (hi_nde_r),
		.load_mask  (load_mask[15:8]),
		.next_data  (hi_nd_r),
		.dir_r      (hi_dir),
		.data_r     (hi_data),
		.pin_out    (PORT_HI_OUT),
		.pin_oe     (PORT_HI_OE)
	);

	// Read mux; output pins read the register, input pins read the synchronised level.
	always_comb
	begin
		rd_byte = POP_RST_ZERO;
		if (idx == POP_IDX_LO_DIR || idx == POP_IDX_HI_DIR)
			rd_byte = POP_RST_ZERO;
		else if (idx == POP_IDX_MODE)
			rd_byte = mode_r;
		else if (idx == POP_IDX_CTRL)
			rd_byte = ctrl_r;
		else if (idx == POP_IDX_HI_NDE)
			rd_byte = hi_nde_r;
		else if (idx == POP_IDX_LO_NDE)
			rd_byte = lo_nde_r;
		else if (idx == POP_IDX_LO_ND)
			rd_byte = (lo_nd_r & nd_mask(lo_view_a5)) | (POP_RESERVED & ~nd_mask(lo_view_a5));
		else if (idx == POP_IDX_LO_ND_G0)
			rd_byte = (lo_nd_r & nd_mask(lo_view_a7)) | (POP_RESERVED & ~nd_mask(lo_view_a7));
		else if (idx == POP_IDX_HI_ND)
			rd_byte = (hi_nd_r & nd_mask(hi_view_a4)) | (POP_RESERVED & ~nd_mask(hi_view_a4));
		else if (idx == POP_IDX_HI_ND_G2)
			rd_byte = (hi_nd_r & nd_mask(hi_view_a6)) | (POP_RESERVED & ~nd_mask(hi_view_a6));
		else if (idx == POP_IDX_LO_DATA)
			rd_byte = (lo_data & lo_dir) | (lo_pin_s & ~lo_dir);
		else if (idx == POP_IDX_HI_DATA)
			rd_byte = (hi_data & hi_dir) | (hi_pin_s & ~hi_dir);
	end

	// Read data is captured in the setup cycle and held through the access phase.
	always_ff @(posedge CLK_SYS or posedge SYS_RST)
	begin
		if (SYS_RST)
			prdata_r <= 32'h0000_0000;
		else if (rd_setup)
			prdata_r <= {24'h00_0000, rd_byte};
	end

endmodule : pop_regs

// >>> hw/pop_sync.sv
// Two-flop synchroniser for the port pin inputs.
`timescale 1ns/1ps
module pop_sync
	import pop_pkg::*;
#(
	parameter int W = 8
)
(
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_r;

	// The first stage feeds only the second stage, to keep metastability contained.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_r   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule : pop_sync
